// File: rtl/rcs_consts.svh
/*
 Constants for the reset and strobe controller: register offsets,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from rtl/.
*/
// Summary of operation
// R01 - Table write strobe only during table write
// R02 - Table write low keeps other strobes high
// R03 - Source holds init input low five cycles
// R04 - Init forces strobes high, data bus released
// R05 - Init clears counter and address synchronously
// R06 - Init disables attention, clears pending flag
// R07 - Init leaves overflow mode unchanged
// R08 - Reset state lasts while init held
// R09 - Clock output is input divided by four
// R10 - Port read enable only during port read
// R11 - Port write strobe only during port write
// R12 - Fetch enable low for every fetch
// R13 - Attention falling edge sets pending flag
// R14 - Init input passes two-stage synchronizer
// R15 - Fetching restarts from address zero
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RCS_OFS_CTRL    4'h0
`define RCS_OFS_CMD     4'h4
`define RCS_OFS_TADDR   4'h8
`define RCS_OFS_STATUS  4'hC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCS_CTRL_ATTN_EN  0
`define RCS_CTRL_OVM      1
`define RCS_CTRL_GRANT    2
`define RCS_CMD_PORT_LSB  4
`define RCS_CMD_DATA_LSB  16
`define RCS_ST_PEND       16
`define RCS_ST_BUSY       17
`define RCS_ST_INRST      18

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RCS_PROG_CNT_RST  16'h0000
`define RCS_PHASE_LAST    2'h3
`define RCS_DIV_RATIO     4
`define RCS_INIT_MIN_CYC  5

`endif

// File: rtl/rcs_pkg.sv
/*
 Types for the reset and strobe controller.
 Assumes rcs_consts.svh holds all numbers.
*/
package rcs_pkg;

  // ----------------------------------------
  // Machine cycle kinds
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_FETCH = 5'h02,
    ST_PRD   = 5'h04,
    ST_PWR   = 5'h08,
    ST_TWR   = 5'h10
  } rcs_state_type;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_PRD  = 2'h1,
    OP_PWR  = 2'h2,
    OP_TWR  = 2'h3
  } rcs_op_type;

endpackage : rcs_pkg

// File: rtl/rcs_ctrl.sv
/*
 Reset and bus-strobe controller with an Avalon-MM register slave.
 Assumes ref_clk is the oscillator input and that data bus pins are
 resolved from data_oe outside this module.
*/
`timescale 1ns/1ps
`include "rcs_consts.svh"

module rcs_ctrl #(
  parameter int AW = 16,
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  // Device pins
  input  wire logic            init_input_n,
  input  wire logic            ext_attention_n,
  output logic                 divided_clock_out,
  output logic                 fetch_enable_n,
  output logic                 port_read_enable_n,
  output logic                 port_write_strobe_n,
  output logic                 table_write_strobe_n,
  output logic [AW-1:0]        addr_out,
  input  wire logic [DW-1:0]   data_in,
  output logic [DW-1:0]        data_out,
  output logic                 data_oe,
  // Avalon-MM slave
  input  wire logic [3:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output logic [31:0]          avs_readdata,
  output logic                 avs_waitrequest
);

  // ----------------------------------------
  // Synchronizers
  // ----------------------------------------
  logic          init_s1_q;
  logic          init_s2_q;
  logic          att_s1_q;
  logic          att_s2_q;
  logic          att_s3_q;
  logic [DW-1:0] din_s1_q;
  logic [DW-1:0] din_s2_q;
  wire           in_reset = !init_s2_q;
  wire           att_fall = att_s3_q && !att_s2_q;

  // Power-on reset counts as init asserted [R14]
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_s1_q <= 1'b0;
      init_s2_q <= 1'b0;
      att_s1_q  <= 1'b1;
      att_s2_q  <= 1'b1;
      att_s3_q  <= 1'b1;
      din_s1_q  <= '0;
      din_s2_q  <= '0;
    end else begin
      init_s1_q <= init_input_n;
      init_s2_q <= init_s1_q;
      att_s1_q  <= ext_attention_n;
      att_s2_q  <= att_s1_q;
      att_s3_q  <= att_s2_q;
      din_s1_q  <= data_in;
      din_s2_q  <= din_s1_q;
    end
  end

  // ----------------------------------------
  // Phase divider
  // ----------------------------------------
  logic [1:0] phase_q;
  logic       clk_out_q;
  wire        cyc_end = (phase_q == `RCS_PHASE_LAST);

  // High in phases 0 and 1, low in 2 and 3 [R09]
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q   <= 2'h0;
      clk_out_q <= 1'b1;
    end else begin
      phase_q   <= phase_q + 2'h1;
      clk_out_q <= (phase_q == 2'h3) || (phase_q == 2'h0);
    end
  end

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  logic                 cmd_pend_q;
  logic                 rd_vld_q;
  wire                  wr_ctrl  = avs_write && (avs_address == `RCS_OFS_CTRL);
  wire                  wr_cmd   = avs_write && (avs_address == `RCS_OFS_CMD);
  wire                  wr_taddr = avs_write && (avs_address == `RCS_OFS_TADDR);
  // Command writes stall until the previous command has been taken
  wire                  cmd_stall = wr_cmd && cmd_pend_q;
  wire                  cmd_acc   = wr_cmd && !cmd_pend_q;
  assign avs_waitrequest = avs_read ? !rd_vld_q : cmd_stall;

  // ----------------------------------------
  // Control and attention
  // ----------------------------------------
  logic attn_en_q;
  logic ovm_q;
  logic pend_q;
  wire  grant = wr_ctrl && avs_writedata[`RCS_CTRL_GRANT] && attn_en_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      attn_en_q <= 1'b0;
      ovm_q     <= 1'b0;
      pend_q    <= 1'b0;
    end else begin
      if (in_reset) begin
        attn_en_q <= 1'b0;                                   // [R06]
      end else if (wr_ctrl) begin
        attn_en_q <= avs_writedata[`RCS_CTRL_ATTN_EN];
      end
      // Init does not touch overflow mode [R07]
      if (wr_ctrl) begin
        ovm_q <= avs_writedata[`RCS_CTRL_OVM];
      end
      // Edge sets win over a grant in the same cycle [R13]
      if (in_reset) begin
        pend_q <= 1'b0;                                      // [R06]
      end else if (att_fall) begin
        pend_q <= 1'b1;                                      // [R13]
      end else if (grant) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Command holding registers
  // ----------------------------------------
  logic [1:0]    cmd_op_q;
  logic [2:0]    cmd_port_q;
  logic [DW-1:0] cmd_data_q;
  logic [AW-1:0] taddr_q;
  logic [DW-1:0] prd_data_q;

  // ----------------------------------------
  // Machine cycle sequencer
  // ----------------------------------------
  rcs_pkg::rcs_state_type st_q;
  rcs_pkg::rcs_state_type st_d;
  logic [AW-1:0]          prog_cnt_q;
  logic [AW-1:0]          prog_cnt_d;
  logic [AW-1:0]          addr_d;
  wire                    take_cmd = cyc_end && !in_reset && cmd_pend_q;

  always_comb begin
    st_d = rcs_pkg::ST_FETCH;
    if (in_reset) begin
      st_d = rcs_pkg::ST_RESET;                              // [R08]
    end else if (cmd_pend_q) begin
      unique case (cmd_op_q)
        rcs_pkg::OP_PRD: st_d = rcs_pkg::ST_PRD;
        rcs_pkg::OP_PWR: st_d = rcs_pkg::ST_PWR;
        rcs_pkg::OP_TWR: st_d = rcs_pkg::ST_TWR;
        default:         st_d = rcs_pkg::ST_FETCH;
      endcase
    end
  end

  // Counter advances only when a fetch cycle completes
  assign prog_cnt_d = in_reset ? `RCS_PROG_CNT_RST :         // [R05]
                      (st_q == rcs_pkg::ST_FETCH) ? prog_cnt_q + 16'h0001 : prog_cnt_q;

  always_comb begin
    addr_d = '0;
    unique case (st_d)
      rcs_pkg::ST_RESET: addr_d = '0;                        // [R05]
      rcs_pkg::ST_FETCH: addr_d = prog_cnt_d;                // [R15]
      rcs_pkg::ST_TWR:   addr_d = taddr_q;
      rcs_pkg::ST_PRD,
      rcs_pkg::ST_PWR:   addr_d = {{(AW-3){1'b0}}, cmd_port_q};
    endcase
  end

  // Clearing waits for the end of the current machine cycle [R05]
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q       <= rcs_pkg::ST_RESET;
      prog_cnt_q <= `RCS_PROG_CNT_RST;
      addr_out   <= '0;
      data_out   <= '0;
      prd_data_q <= '0;
    end else if (cyc_end) begin
      st_q     <= st_d;
      prog_cnt_q <= prog_cnt_d;
      addr_out <= addr_d;
      data_out <= cmd_data_q;
      if (st_q == rcs_pkg::ST_PRD) begin
        prd_data_q <= din_s2_q;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_pend_q <= 1'b0;
      cmd_op_q   <= 2'h0;
      cmd_port_q <= 3'h0;
      cmd_data_q <= '0;
      taddr_q    <= '0;
    end else begin
      // Commands seen during init are dropped, not deferred
      if (cmd_acc && !in_reset) begin
        cmd_pend_q <= (avs_writedata[1:0] != rcs_pkg::OP_NONE);
        cmd_op_q   <= avs_writedata[1:0];
        cmd_port_q <= avs_writedata[`RCS_CMD_PORT_LSB +: 3];
        cmd_data_q <= avs_writedata[`RCS_CMD_DATA_LSB +: DW];
      end else if (take_cmd || in_reset) begin
        cmd_pend_q <= 1'b0;
      end
      if (wr_taddr) begin
        taddr_q <= avs_writedata[AW-1:0];
      end
    end
  end

  // ----------------------------------------
  // Strobes and data bus
  // ----------------------------------------
  wire act_ph = (phase_q != 2'h0);
  wire wr_ph  = phase_q[1];
  // One-hot state keeps the strobes mutually exclusive [R02]
  assign divided_clock_out    = clk_out_q;                          // [R09]
  assign fetch_enable_n       = !((st_q == rcs_pkg::ST_FETCH) && act_ph); // [R12]
  assign port_read_enable_n   = !((st_q == rcs_pkg::ST_PRD) && act_ph);   // [R10]
  assign port_write_strobe_n  = !((st_q == rcs_pkg::ST_PWR) && wr_ph);    // [R11]
  assign table_write_strobe_n = !((st_q == rcs_pkg::ST_TWR) && wr_ph);    // [R01]
  // Reset state drives no strobe and no data [R04]
  assign data_oe = ((st_q == rcs_pkg::ST_PWR) || (st_q == rcs_pkg::ST_TWR)) && act_ph;

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  wire [31:0] st_word = {13'h0000, in_reset, cmd_pend_q, pend_q, prog_cnt_q};
  wire [31:0] rd_mux  =
    (avs_address == `RCS_OFS_CTRL)   ? {29'h0000_0000, 1'b0, ovm_q, attn_en_q} :
    (avs_address == `RCS_OFS_CMD)    ? {16'h0000, prd_data_q} :
    (avs_address == `RCS_OFS_TADDR)  ? {16'h0000, taddr_q} :
    (avs_address == `RCS_OFS_STATUS) ? st_word : 32'h0000_0000;

  // Reads take one wait cycle so that read data come from a flop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_vld_q     <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_vld_q <= avs_read && !rd_vld_q;
      if (avs_read && !rd_vld_q) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_twr_only;
    @(posedge ref_clk) disable iff (!rst_b)
    !table_write_strobe_n |-> (st_q == rcs_pkg::ST_TWR) && data_oe;
  endproperty
  a_twr_only: assert property (p_twr_only) else $error("table strobe outside write"); // [R01]

  property p_twr_excl;
    @(posedge ref_clk) disable iff (!rst_b)
    !table_write_strobe_n |-> fetch_enable_n && port_read_enable_n && port_write_strobe_n;
  endproperty
  a_twr_excl: assert property (p_twr_excl) else $error("strobe overlaps table write"); // [R02]

  property p_rst_quiet;
    @(posedge ref_clk) disable iff (!rst_b)
    in_reset && (st_q == rcs_pkg::ST_RESET) |-> fetch_enable_n && port_read_enable_n
      && port_write_strobe_n && table_write_strobe_n && !data_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("bus active in reset"); // [R04]

  property p_cnt_clr;
    @(posedge ref_clk) disable iff (!rst_b)
    in_reset && cyc_end |=> (prog_cnt_q == 16'h0000) && (addr_out == '0);
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared"); // [R05]

  property p_attn_rst;
    @(posedge ref_clk) disable iff (!rst_b)
    in_reset |=> !attn_en_q && !pend_q;
  endproperty
  a_attn_rst: assert property (p_attn_rst) else $error("attention survives reset"); // [R06]

  property p_ovm_keep;
    @(posedge ref_clk) disable iff (!rst_b)
    in_reset && !wr_ctrl |=> $stable(ovm_q);
  endproperty
  a_ovm_keep: assert property (p_ovm_keep) else $error("overflow mode changed"); // [R07]

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    in_reset && cyc_end |=> (st_q == rcs_pkg::ST_RESET);
  endproperty
  a_hold: assert property (p_hold) else $error("left reset early"); // [R08]

  property p_clk_div;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(divided_clock_out) |=> divided_clock_out ##1 !divided_clock_out [*2]
      ##1 divided_clock_out;
  endproperty
  a_clk_div: assert property (p_clk_div) else $error("clock output not quarter rate"); // [R09]

  property p_prd;
    @(posedge ref_clk) disable iff (!rst_b)
    !port_read_enable_n |-> (st_q == rcs_pkg::ST_PRD) && fetch_enable_n && !data_oe;
  endproperty
  a_prd: assert property (p_prd) else $error("read enable misplaced"); // [R10]

  property p_pwr;
    @(posedge ref_clk) disable iff (!rst_b)
    !port_write_strobe_n |-> (st_q == rcs_pkg::ST_PWR) && data_oe && table_write_strobe_n;
  endproperty
  a_pwr: assert property (p_pwr) else $error("write strobe misplaced"); // [R11]

  property p_fetch;
    @(posedge ref_clk) disable iff (!rst_b)
    $fell(fetch_enable_n) |-> !fetch_enable_n [*3] ##1 fetch_enable_n;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch enable wrong length"); // [R12]

  property p_att;
    @(posedge ref_clk) disable iff (!rst_b)
    att_fall && !in_reset |=> pend_q;
  endproperty
  a_att: assert property (p_att) else $error("attention edge lost"); // [R13]

  property p_sync;
    @(posedge ref_clk) disable iff (!rst_b)
    !init_input_n ##1 !init_input_n |=> in_reset;
  endproperty
  a_sync: assert property (p_sync) else $error("init not seen after two flops"); // [R14]

  property p_start;
    @(posedge ref_clk) disable iff (!rst_b)
    (st_q == rcs_pkg::ST_RESET) ##1 (st_q == rcs_pkg::ST_FETCH) |-> (addr_out == '0);
  endproperty
  a_start: assert property (p_start) else $error("fetch not from zero"); // [R15]

  c_twr: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(table_write_strobe_n));
  c_prd: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(port_read_enable_n));
  c_rel: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(in_reset));
  c_grant: cover property (@(posedge ref_clk) disable iff (!rst_b) grant && pend_q);

endmodule : rcs_ctrl

// File: bench/rcs_far_model.sv
/*
 Far side model: external reset source and peripheral data bus.
 Assumes the bench raises init_req and supplies the port read value.
*/
`timescale 1ns/1ps
module rcs_far_model (
  // Clock
  input  wire logic        ref_clk,
  // Requests from the bench
  input  wire logic        init_req,
  input  wire logic [15:0] rd_value,
  // Device pins
  input  wire logic        port_read_enable_n,
  output logic             init_input_n,
  output logic [15:0]      data_in
);
  logic [4:0]  hold_q = 5'h00;
  logic [1:0]  drv_q  = 2'h0;
  logic [15:0] junk_q = 16'h5a5a;

  // ----------------------------------------
  // Init pulse, never shorter than five output clocks
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    hold_q <= init_req ? 5'h14 : (hold_q != 5'h00) ? hold_q - 5'h01 : hold_q;
  end
  assign init_input_n = !init_req && (hold_q == 5'h00);

  // ----------------------------------------
  // Data bus: short hold, then a changing pattern
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    drv_q  <= (port_read_enable_n === 1'b0) ? 2'h2 : (drv_q != 2'h0) ? drv_q - 2'h1 : drv_q;
    junk_q <= ~junk_q;
  end
  assign data_in = (port_read_enable_n === 1'b0 || drv_q != 2'h0) ? rd_value : junk_q;
endmodule : rcs_far_model

// File: bench/reset_clock_strobe_ctrl_bench.sv
/*
 Self-checking bench for the reset and strobe controller.
 Assumes rcs_far_model stands on the device pins; no other parts.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module reset_clock_strobe_ctrl_bench;
  typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d;} rcs_row_type;
  localparam rcs_row_type ROWS [6] = '{'{1'b1, 4'h0, 32'h0000_0003},
    '{1'b0, 4'h0, 32'h0000_0003}, '{1'b1, 4'h8, 32'h0001_2345},
    '{1'b0, 4'h8, 32'h0000_2345}, '{1'b1, 4'h2, 32'hffff_ffff}, '{1'b0, 4'h2, 32'h0000_0000}};
  logic        ref_clk = 1'b0, rst_b = 1'b0, init_req = 1'b0, ext_attention_n = 1'b1;
  logic [15:0] rd_value = 16'ha5c3;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic        init_input_n, divided_clock_out, fetch_enable_n, data_oe, avs_waitrequest;
  logic        port_read_enable_n, port_write_strobe_n, table_write_strobe_n;
  logic [15:0] addr_out, data_in, data_out, pw_data, pw_addr, tw_data, tw_addr, cd, s;
  int          err_total = 0, check_count = 0, n_prd = 0, n_pwr = 0, n_twr = 0, n_fe = 0;
  int          b_prd, b_pwr, b_twr, n;
  wire  [4:0]  quiet = {fetch_enable_n, port_read_enable_n, port_write_strobe_n,
                        table_write_strobe_n, data_oe};

  rcs_ctrl rcs_ctrl_i (.ref_clk(ref_clk), .rst_b(rst_b), .init_input_n(init_input_n),
    .ext_attention_n(ext_attention_n), .divided_clock_out(divided_clock_out),
    .fetch_enable_n(fetch_enable_n), .port_read_enable_n(port_read_enable_n),
    .port_write_strobe_n(port_write_strobe_n), .table_write_strobe_n(table_write_strobe_n),
    .addr_out(addr_out), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  rcs_far_model rcs_far_model_i (.ref_clk(ref_clk), .init_req(init_req), .rd_value(rd_value),
    .port_read_enable_n(port_read_enable_n), .init_input_n(init_input_n), .data_in(data_in));

  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Bus cycles and closing
  // ----------------------------------------
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1; else avs_read <= 1'b1;
    do begin @(posedge ref_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k == 50) err_total++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av_xfer

  task automatic pulse_attn();
    @(posedge ref_clk) ext_attention_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ext_attention_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : pulse_attn

  task automatic complete_run();
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Strobe monitor, away from the active edge
  // ----------------------------------------
  always @(negedge ref_clk) if (rst_b === 1'b1) begin
    if (port_read_enable_n === 1'b0) n_prd++;
    if (fetch_enable_n === 1'b0) n_fe++;
    if (port_write_strobe_n === 1'b0) begin
      n_pwr++;
      pw_data = data_out;
      pw_addr = addr_out;
      `CHK(data_oe, 1'b1)
    end
    if (table_write_strobe_n === 1'b0) begin
      n_twr++;
      tw_data = data_out;
      tw_addr = addr_out;
      `CHK(data_oe, 1'b1)
      `CHK({fetch_enable_n, port_read_enable_n, port_write_strobe_n}, 3'h7)
    end
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end

  initial begin
    repeat (11) @(posedge ref_clk);
    `CHK(quiet, 5'h1e)
    `CHK(addr_out, 16'h0000)
    @(posedge ref_clk) rst_b <= 1'b1;
    repeat (12) @(posedge ref_clk);
    for (int i = 0; i < 16; i++) begin @(posedge ref_clk); s[i] = divided_clock_out; end
    `CHK(s[11:0], s[15:4])
    `CHK(s[1:0] ^ s[3:2], 2'h3)
    b_prd = n_fe;
    repeat (40) @(posedge ref_clk);
    `CHK(n_fe - b_prd, 30)
    foreach (ROWS[i]) begin
      av_xfer(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].wr) `CHK(rd, ROWS[i].d)
    end
    // One command of each kind, counting strobe cycles
    for (int k = 1; k < 4; k++) begin
      b_prd = n_prd;
      b_pwr = n_pwr;
      b_twr = n_twr;
      cd = 16'h3c00 | 16'(k);
      av_xfer(1'b1, 4'h4, {cd, 9'h000, 3'h5, 2'h0, 2'(k)});
      repeat (16) @(posedge ref_clk);
      `CHK(n_prd - b_prd, (k == 1) ? 3 : 0)
      `CHK(n_pwr - b_pwr, (k == 2) ? 2 : 0)
      `CHK(n_twr - b_twr, (k == 3) ? 2 : 0)
    end
    `CHK(pw_data, 16'h3c02)
    `CHK(pw_addr[2:0], 3'h5)
    `CHK(tw_data, 16'h3c03)
    `CHK(tw_addr, 16'h2345)
    // Second command is accepted while the first runs; first data stays on the bus
    b_pwr = n_pwr;
    b_twr = n_twr;
    av_xfer(1'b1, 4'h4, 32'h7e02_0052);
    av_xfer(1'b1, 4'h4, 32'h7e03_0003);
    repeat (16) @(posedge ref_clk);
    `CHK(n_pwr - b_pwr, 2)
    `CHK(n_twr - b_twr, 2)
    `CHK(pw_data, 16'h7e02)
    `CHK(tw_data, 16'h7e03)
    av_xfer(1'b0, 4'h4, 32'h0000_0000);
    `CHK(rd, 32'h0000_a5c3)
    // Attention set, granted, set again, then init
    pulse_attn();
    av_xfer(1'b0, 4'hc, 32'h0000_0000);
    `CHK(rd[16], 1'b1)
    av_xfer(1'b1, 4'h0, 32'h0000_0007);
    av_xfer(1'b0, 4'hc, 32'h0000_0000);
    `CHK(rd[16], 1'b0)
    pulse_attn();
    init_req <= 1'b1;
    repeat (16) @(posedge ref_clk);
    for (int i = 0; i < 24; i++) begin
      @(posedge ref_clk);
      `CHK(quiet, 5'h1e)
      `CHK(addr_out, 16'h0000)
    end
    av_xfer(1'b0, 4'hc, 32'h0000_0000);
    `CHK(rd[18:0], 19'h4_0000)
    av_xfer(1'b0, 4'h0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002)
    b_pwr = n_pwr;
    av_xfer(1'b1, 4'h4, 32'h1234_0002);
    repeat (8) @(posedge ref_clk);
    `CHK(n_pwr - b_pwr, 0)
    init_req <= 1'b0;
    n = 0;
    while (fetch_enable_n !== 1'b0 && n < 80) begin @(posedge ref_clk); n++; end
    `CHK(fetch_enable_n, 1'b0)
    `CHK(addr_out, 16'h0000)
    complete_run();
  end
endmodule : reset_clock_strobe_ctrl_bench
